/* hot_swap_fault_sequencer_pkg.sv */
// Constants shared by the hot-swap sequencing and fault logic.
// Assumes a command decoder outside maps serial-bus codes onto the register port.
package hot_swap_fault_sequencer_pkg;
	// Register offsets (command codes).
	localparam logic [7:0] SUMMARY_STATUS_ADDR = 8'h79;
	localparam logic [7:0] INPUT_STATUS_ADDR = 8'h7C;
	localparam logic [7:0] VENDOR_STATUS_ADDR = 8'h80;
	localparam logic [7:0] ALERT_SUPPRESS_MASK_ADDR = 8'hD8;
	localparam logic [7:0] PROTECTION_CONFIG_ADDR = 8'hD9;
	localparam logic [7:0] DIAGNOSTIC_SUMMARY_ADDR = 8'hE1;
	// Reset values.
	localparam logic [15:0] ALERT_MASK_RESET = 16'h0000;
	localparam logic [7:0] PROT_CONFIG_RESET = 8'h00;
	// Field positions.
	localparam int SUMMARY_INPUT_BIT = 13;
	localparam int INPUT_OC_BIT = 2;
	localparam int VENDOR_CB_BIT = 0;
	localparam int DIAG_OC_OP_BIT = 11;
	localparam int DIAG_CB_BIT = 10;
	localparam int DIAG_LATCHED_BIT = 8;
	localparam logic [15:0] DIAG_STICKY_BITS = 16'h0C00;
	localparam int CFG_RETRY_LSB = 0;
	localparam int CFG_CL_VALUE_BIT = 3;
	localparam int CFG_CL_OVERRIDE_BIT = 4;
	localparam int CFG_CB_VALUE_BIT = 5;
	localparam int CFG_CB_OVERRIDE_BIT = 6;
	// Retry selection codes in the protection configuration.
	localparam logic [2:0] RETRY_FROM_PIN = 3'h0;
	localparam logic [2:0] RETRY_UNLIMITED = 3'h7;
	// Number of rising timer ramps in an automatic restart sequence.
	localparam logic [2:0] RESTART_RAMPS_LAST = 3'h7;
	// Synchronised comparator and pin input positions.
	localparam int IN_POR = 0;
	localparam int IN_UV = 1;
	localparam int IN_OV = 2;
	localparam int IN_CURLIM = 3;
	localparam int IN_POWLIM = 4;
	localparam int IN_CB = 5;
	localparam int IN_THI = 6;
	localparam int IN_TMID = 7;
	localparam int IN_TLO = 8;
	localparam int IN_RANGE = 9;
	localparam int IN_RETRY = 10;
	localparam int IN_COUNT = 11;

	typedef enum logic [3:0] {
		S_POWERUP, S_INSERT, S_INSERT_DISCHARGE, S_RUN, S_RETRY_DOWN, S_RETRY_UP, S_LATCHED
	} seq_state_t;
endpackage

/* hot_swap_fault_sequencer.sv */
// Sequencing, gate and timer current selection, fault status and alert of a hot-swap controller.
// Assumes analog comparators give digital levels and each select line switches one current source.
// What this block does
// - Strongest gate pull-down when supply first appears.
// - Medium pull-down holds gate throughout insertion.
// - Gate charging source on in normal operation.
// - Fault timer source on while limiting.
// - Limiting ends early: normal, strong timer sink.
// - Timer high while limiting: fault, medium pull-down.
// - Undervoltage or overvoltage: medium gate pull-down.
// - Range pin high selects lower current limit.
// - Current-limit timeout sets input and diagnostic bits.
// - Configuration can override the current-limit range.
// - Breaker trip: strongest pull-down, fault timeout starts.
// - Breaker clear: release strong pull-down, limits resume.
// - Breaker trip sets vendor and diagnostic fault bits.
// - Configuration can override the breaker multiple.
// - Power limit modulates gate through external loop.
// - Power-limit timeout sets the same status bits.
// - Restart pin high latches off, weak timer sink.
// - Latched restart accepted only with timer low.
// - Latched-off flag high while latched off.
// - Auto restart ramps timer up seven times.
// - Eighth ramp reaching lowest threshold turns gate on.
// - Retry count from pin or configuration.
// - Insertion charges timer to upper threshold, then discharges.
`timescale 1ns/1ns
`default_nettype none
module hot_swap_fault_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic porOk,
	input wire logic undervoltBelow,
	input wire logic overvoltAbove,
	input wire logic currentLimitActive,
	input wire logic powerLimitActive,
	input wire logic breakerTrip,
	input wire logic timerAboveHigh,
	input wire logic timerAboveMid,
	input wire logic timerBelowLow,
	input wire logic limitRangePin,
	input wire logic restartSelectPin,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	input wire logic clearFaults,
	input wire logic onOffRestart,
	output logic gatePullStrong,
	output logic gatePullMedium,
	output logic gateSource,
	output logic timerInsertSource,
	output logic timerFaultSource,
	output logic timerSinkStrong,
	output logic timerSinkWeak,
	output logic limitLowRange,
	output logic breakerHighMultiple,
	input wire logic alertLineNIn,
	output logic alertLineNOut,
	output logic alertLineNOe
);
	// Input synchroniser: three stages, a bit changes once stages two and three agree.
	logic [hot_swap_fault_sequencer_pkg::IN_COUNT-1:0] syncS1_q, syncS2_q, syncS3_q, inFilt_q;
	logic [hot_swap_fault_sequencer_pkg::IN_COUNT-1:0] rawIn;
	assign rawIn = {restartSelectPin, limitRangePin, timerBelowLow, timerAboveMid, timerAboveHigh,
		breakerTrip, powerLimitActive, currentLimitActive, overvoltAbove, undervoltBelow, porOk};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncS1_q <= '0;
			syncS2_q <= '0;
			syncS3_q <= '0;
			inFilt_q <= '0;
		end else begin
			syncS1_q <= rawIn;
			syncS2_q <= syncS1_q;
			syncS3_q <= syncS2_q;
			inFilt_q <= (syncS2_q & syncS3_q) | (inFilt_q & (syncS2_q ^ syncS3_q));
		end
	end

	logic supplyOk, underV, overV, curLim, powLim, cbTrip, tHigh, tMid, tLow, rangeHigh, retryHigh;
	assign {retryHigh, rangeHigh, tLow, tMid, tHigh, cbTrip, powLim, curLim, overV, underV, supplyOk} = inFilt_q;

	// Host-writable registers.
	logic [15:0] alertMask_q;
	logic [7:0] protConfig_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alertMask_q <= hot_swap_fault_sequencer_pkg::ALERT_MASK_RESET;
			protConfig_q <= hot_swap_fault_sequencer_pkg::PROT_CONFIG_RESET;
		end else if (regWrEn) begin
			if (regAddr == hot_swap_fault_sequencer_pkg::ALERT_SUPPRESS_MASK_ADDR) begin
				alertMask_q <= regWrData;
			end
			if (regAddr == hot_swap_fault_sequencer_pkg::PROTECTION_CONFIG_ADDR) begin
				protConfig_q <= regWrData[7:0];
			end
		end
	end

	// Range and breaker multiple selection; the analog loop modulates the gate itself.
	logic [2:0] retryMode;
	assign retryMode = protConfig_q[hot_swap_fault_sequencer_pkg::CFG_RETRY_LSB +: 3];
	assign limitLowRange = protConfig_q[hot_swap_fault_sequencer_pkg::CFG_CL_OVERRIDE_BIT] ?
		protConfig_q[hot_swap_fault_sequencer_pkg::CFG_CL_VALUE_BIT] : rangeHigh;
	// The larger breaker multiple goes with the higher limit, chosen by the range pin low.
	assign breakerHighMultiple = protConfig_q[hot_swap_fault_sequencer_pkg::CFG_CB_OVERRIDE_BIT] ?
		protConfig_q[hot_swap_fault_sequencer_pkg::CFG_CB_VALUE_BIT] : !rangeHigh;

	// Retry budget: code maps to a count, unlimited bypasses the counter.
	function automatic logic [4:0] retryBudget(input logic [2:0] mode);
		case (mode)
			3'h1: retryBudget = 5'h00;
			3'h2: retryBudget = 5'h01;
			3'h3: retryBudget = 5'h02;
			3'h4: retryBudget = 5'h04;
			3'h5: retryBudget = 5'h08;
			3'h6: retryBudget = 5'h10;
			default: retryBudget = 5'h00;
		endcase
	endfunction

	logic unlimitedRetry, pinLatchOff;
	// Pin high with no configuration means no retries; low or floating means unlimited.
	assign pinLatchOff = (retryMode == hot_swap_fault_sequencer_pkg::RETRY_FROM_PIN) && retryHigh;
	assign unlimitedRetry = (retryMode == hot_swap_fault_sequencer_pkg::RETRY_UNLIMITED) ||
		((retryMode == hot_swap_fault_sequencer_pkg::RETRY_FROM_PIN) && !retryHigh);

	// Sequencer.
	hot_swap_fault_sequencer_pkg::seq_state_t state_q;
	logic [2:0] rampCount_q;
	logic [4:0] retriesLeft_q;
	logic restartPending_q;
	logic limiting, faultTimeout, retryAllowed;
	assign limiting = curLim || powLim || cbTrip;
	assign faultTimeout = (state_q == hot_swap_fault_sequencer_pkg::S_RUN) && limiting && tHigh && !underV && !overV;
	assign retryAllowed = !pinLatchOff && (unlimitedRetry || (retriesLeft_q != 5'h00));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= hot_swap_fault_sequencer_pkg::S_POWERUP;
		end else if (!supplyOk) begin
			state_q <= hot_swap_fault_sequencer_pkg::S_POWERUP;
		end else begin
			case (state_q)
				hot_swap_fault_sequencer_pkg::S_POWERUP: begin
					state_q <= hot_swap_fault_sequencer_pkg::S_INSERT;
				end
				hot_swap_fault_sequencer_pkg::S_INSERT: begin
					if (tHigh) begin
						state_q <= hot_swap_fault_sequencer_pkg::S_INSERT_DISCHARGE;
					end
				end
				hot_swap_fault_sequencer_pkg::S_INSERT_DISCHARGE: begin
					if (tLow) begin
						state_q <= hot_swap_fault_sequencer_pkg::S_RUN;
					end
				end
				hot_swap_fault_sequencer_pkg::S_RUN: begin
					if (faultTimeout) begin
						state_q <= retryAllowed ? hot_swap_fault_sequencer_pkg::S_RETRY_DOWN :
							hot_swap_fault_sequencer_pkg::S_LATCHED;
					end
				end
				hot_swap_fault_sequencer_pkg::S_RETRY_DOWN: begin
					if (rampCount_q == hot_swap_fault_sequencer_pkg::RESTART_RAMPS_LAST) begin
						if (tLow) begin
							state_q <= hot_swap_fault_sequencer_pkg::S_RUN;
						end
					end else if (!tMid) begin
						state_q <= hot_swap_fault_sequencer_pkg::S_RETRY_UP;
					end
				end
				hot_swap_fault_sequencer_pkg::S_RETRY_UP: begin
					if (tHigh) begin
						state_q <= hot_swap_fault_sequencer_pkg::S_RETRY_DOWN;
					end
				end
				hot_swap_fault_sequencer_pkg::S_LATCHED: begin
					if (restartPending_q && tLow) begin
						state_q <= hot_swap_fault_sequencer_pkg::S_INSERT;
					end
				end
				default: state_q <= hot_swap_fault_sequencer_pkg::S_POWERUP;
			endcase
		end
	end

	// Counts completed rising ramps of one restart sequence.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rampCount_q <= 3'h0;
		end else if (state_q == hot_swap_fault_sequencer_pkg::S_RUN) begin
			rampCount_q <= 3'h0;
		end else if (state_q == hot_swap_fault_sequencer_pkg::S_RETRY_UP && tHigh) begin
			rampCount_q <= rampCount_q + 3'h1;
		end
	end

	// The budget refills on each fresh insertion and drops by one per restart attempt.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			retriesLeft_q <= 5'h00;
		end else if (state_q == hot_swap_fault_sequencer_pkg::S_INSERT) begin
			retriesLeft_q <= retryBudget(retryMode);
		end else if (faultTimeout && retryAllowed && !unlimitedRetry) begin
			retriesLeft_q <= retriesLeft_q - 5'h01;
		end
	end

	// Enable pulsed low or an on/off command arms a restart out of latch-off.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			restartPending_q <= 1'b0;
		end else if (state_q != hot_swap_fault_sequencer_pkg::S_LATCHED) begin
			restartPending_q <= 1'b0;
		end else if (underV || onOffRestart) begin
			restartPending_q <= 1'b1;
		end
	end

	// Current source selection; the gate modes are prioritised so exactly one is active.
	logic gateOffMedium, runSupplyBad;
	assign runSupplyBad = underV || overV;
	always_comb begin
		gatePullStrong = 1'b0;
		gateOffMedium = 1'b1;
		timerInsertSource = 1'b0;
		timerFaultSource = 1'b0;
		timerSinkStrong = 1'b0;
		timerSinkWeak = 1'b0;
		case (state_q)
			hot_swap_fault_sequencer_pkg::S_POWERUP: begin
				gatePullStrong = 1'b1;
				gateOffMedium = 1'b0;
				timerSinkStrong = 1'b1;
			end
			hot_swap_fault_sequencer_pkg::S_INSERT: begin
				timerInsertSource = 1'b1;
			end
			hot_swap_fault_sequencer_pkg::S_INSERT_DISCHARGE: begin
				timerSinkStrong = 1'b1;
			end
			hot_swap_fault_sequencer_pkg::S_RUN: begin
				if (runSupplyBad) begin
					timerSinkStrong = 1'b1;
				end else begin
					gateOffMedium = 1'b0;
					gatePullStrong = cbTrip;
					timerFaultSource = curLim || powLim || cbTrip;
					timerSinkStrong = !(curLim || powLim || cbTrip);
				end
			end
			hot_swap_fault_sequencer_pkg::S_RETRY_DOWN: begin
				timerSinkWeak = 1'b1;
			end
			hot_swap_fault_sequencer_pkg::S_RETRY_UP: begin
				timerFaultSource = 1'b1;
			end
			hot_swap_fault_sequencer_pkg::S_LATCHED: begin
				timerSinkWeak = 1'b1;
			end
			default: begin
				timerSinkStrong = 1'b1;
			end
		endcase
	end
	assign gatePullMedium = gateOffMedium;
	assign gateSource = !gatePullStrong && !gateOffMedium;

	// Sticky fault bits: a new event in the clear cycle keeps the bit set.
	logic ocOpFault_q, breakerFault_q, cbTripSeen_q, ocOpSet, breakerSet;
	assign ocOpSet = faultTimeout && (curLim || powLim);
	assign breakerSet = (state_q == hot_swap_fault_sequencer_pkg::S_RUN) && cbTrip && !cbTripSeen_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ocOpFault_q <= 1'b0;
			breakerFault_q <= 1'b0;
			cbTripSeen_q <= 1'b0;
		end else begin
			cbTripSeen_q <= cbTrip;
			ocOpFault_q <= ocOpSet || (ocOpFault_q && !clearFaults);
			breakerFault_q <= breakerSet || (breakerFault_q && !clearFaults);
		end
	end

	logic latchedOff;
	logic [15:0] diagWord, summaryWord;
	logic [7:0] inputWord, vendorWord;
	assign latchedOff = (state_q == hot_swap_fault_sequencer_pkg::S_LATCHED);
	always_comb begin
		diagWord = 16'h0000;
		diagWord[hot_swap_fault_sequencer_pkg::DIAG_OC_OP_BIT] = ocOpFault_q;
		diagWord[hot_swap_fault_sequencer_pkg::DIAG_CB_BIT] = breakerFault_q;
		diagWord[hot_swap_fault_sequencer_pkg::DIAG_LATCHED_BIT] = latchedOff;
		inputWord = 8'h00;
		inputWord[hot_swap_fault_sequencer_pkg::INPUT_OC_BIT] = ocOpFault_q;
		vendorWord = 8'h00;
		vendorWord[hot_swap_fault_sequencer_pkg::VENDOR_CB_BIT] = breakerFault_q;
		summaryWord = 16'h0000;
		summaryWord[hot_swap_fault_sequencer_pkg::SUMMARY_INPUT_BIT] = |inputWord;
	end

	// The latched-off flag is a live state, not a fault, so only sticky bits can alert.
	logic alertActive;
	assign alertActive = |(diagWord & hot_swap_fault_sequencer_pkg::DIAG_STICKY_BITS & ~alertMask_q);
	assign alertLineNOut = 1'b0;
	assign alertLineNOe = alertActive;

	// Read data is registered one cycle after the address; unmapped codes read zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 16'h0000;
		end else begin
			case (regAddr)
				hot_swap_fault_sequencer_pkg::SUMMARY_STATUS_ADDR: regRdData <= summaryWord;
				hot_swap_fault_sequencer_pkg::INPUT_STATUS_ADDR: regRdData <= {8'h00, inputWord};
				hot_swap_fault_sequencer_pkg::VENDOR_STATUS_ADDR: regRdData <= {8'h00, vendorWord};
				hot_swap_fault_sequencer_pkg::ALERT_SUPPRESS_MASK_ADDR: regRdData <= alertMask_q;
				hot_swap_fault_sequencer_pkg::PROTECTION_CONFIG_ADDR: regRdData <= {8'h00, protConfig_q};
				hot_swap_fault_sequencer_pkg::DIAGNOSTIC_SUMMARY_ADDR: regRdData <= diagWord;
				default: regRdData <= 16'h0000;
			endcase
		end
	end

	// Checks.
	sequence s_runLimiting;
		(state_q == hot_swap_fault_sequencer_pkg::S_RUN) && !underV && !overV && (curLim || powLim);
	endsequence
	sequence s_timeoutReached;
		s_runLimiting ##0 tHigh;
	endsequence
	property p_powerupStrong;
		@(posedge clk) disable iff (!rst_n)
		!supplyOk |=> gatePullStrong && timerSinkStrong;
	endproperty
	a_powerupStrong: assert property (p_powerupStrong) else $error("gate not strongly pulled at power up");
	property p_insertHold;
		@(posedge clk) disable iff (!rst_n)
		(state_q == hot_swap_fault_sequencer_pkg::S_INSERT) |-> gatePullMedium && timerInsertSource && !gateSource;
	endproperty
	a_insertHold: assert property (p_insertHold) else $error("gate not held during insertion");
	property p_oneGateMode;
		@(posedge clk) disable iff (!rst_n)
		$onehot({gatePullStrong, gatePullMedium, gateSource});
	endproperty
	a_oneGateMode: assert property (p_oneGateMode) else $error("gate modes not exclusive");
	property p_limitCharges;
		@(posedge clk) disable iff (!rst_n)
		s_runLimiting |-> timerFaultSource && !timerSinkStrong && !timerSinkWeak;
	endproperty
	a_limitCharges: assert property (p_limitCharges) else $error("timer not charged while limiting");
	property p_timeoutOff;
		@(posedge clk) disable iff (!rst_n)
		s_timeoutReached ##0 supplyOk ##1 supplyOk |-> gatePullMedium && !gateSource;
	endproperty
	a_timeoutOff: assert property (p_timeoutOff) else $error("gate not turned off after timeout");
	logic regAddrIndependentAlert;
	assign regAddrIndependentAlert = alertMask_q[hot_swap_fault_sequencer_pkg::DIAG_OC_OP_BIT] || alertLineNOe;
	property p_timeoutStatus;
		@(posedge clk) disable iff (!rst_n)
		s_timeoutReached ##1 !clearFaults |-> ocOpFault_q && regAddrIndependentAlert;
	endproperty
	a_timeoutStatus: assert property (p_timeoutStatus) else $error("overcurrent fault not flagged");
	property p_breakerStrong;
		@(posedge clk) disable iff (!rst_n)
		(state_q == hot_swap_fault_sequencer_pkg::S_RUN) && cbTrip && !underV && !overV |-> gatePullStrong;
	endproperty
	a_breakerStrong: assert property (p_breakerStrong) else $error("breaker trip without strong pull-down");
	property p_breakerFlag;
		@(posedge clk) disable iff (!rst_n)
		breakerSet ##1 !clearFaults |-> breakerFault_q && vendorWord[hot_swap_fault_sequencer_pkg::VENDOR_CB_BIT];
	endproperty
	a_breakerFlag: assert property (p_breakerFlag) else $error("breaker fault bit not set");
	property p_latchHold;
		@(posedge clk) disable iff (!rst_n)
		latchedOff && !tLow && supplyOk |=> latchedOff && diagWord[hot_swap_fault_sequencer_pkg::DIAG_LATCHED_BIT];
	endproperty
	a_latchHold: assert property (p_latchHold) else $error("latch left with timer not low");
	property p_alertLevel;
		@(posedge clk) disable iff (!rst_n)
		alertLineNOe == |({ocOpFault_q, breakerFault_q} &
			~{alertMask_q[hot_swap_fault_sequencer_pkg::DIAG_OC_OP_BIT], alertMask_q[hot_swap_fault_sequencer_pkg::DIAG_CB_BIT]});
	endproperty
	a_alertLevel: assert property (p_alertLevel) else $error("alert does not follow unmasked faults");
	property p_rampTurn;
		@(posedge clk) disable iff (!rst_n)
		(state_q == hot_swap_fault_sequencer_pkg::S_RETRY_DOWN) && !tMid && supplyOk &&
			(rampCount_q != hot_swap_fault_sequencer_pkg::RESTART_RAMPS_LAST) |=> timerFaultSource;
	endproperty
	a_rampTurn: assert property (p_rampTurn) else $error("restart ramp did not turn upward");
endmodule
`default_nettype wire

/* timer_cap_model.sv */
// Behavioural timer capacitor with its three threshold comparators.
// Assumes each select line switches one current, scaled here to steps per clock.
`timescale 1ns/1ns
`default_nettype none
module timer_cap_model (
	input wire logic clk,
	input wire logic insertSrc,
	input wire logic faultSrc,
	input wire logic sinkStrong,
	input wire logic sinkWeak,
	output logic aboveHigh,
	output logic aboveMid,
	output logic belowLow
);
	int level = 0;
	int nxt;
	// Steps keep the ratio of charge to weak discharge so a restart ramp lasts long enough to count.
	always_comb nxt = level + (insertSrc ? 4 : 0) + (faultSrc ? 8 : 0) - (sinkStrong ? 20 : 0) - (sinkWeak ? 2 : 0);
	// The capacitor cannot go below the rail nor far above the upper threshold.
	always @(posedge clk) begin
		level <= (nxt < 0) ? 0 : ((nxt > 420) ? 420 : nxt);
	end
	assign aboveHigh = (level >= 390);
	assign aboveMid = (level > 120);
	assign belowLow = (level < 30);
endmodule
`default_nettype wire

/* hot_swap_fault_sequencer_test.sv */
// Self-checking bench for the hot-swap sequencing and fault logic.
// Assumes the timer capacitor model answers the timer select lines.
`timescale 1ns/1ns
`default_nettype none
module hot_swap_fault_sequencer_test;
	typedef struct packed {logic [7:0] cfg; logic pin; logic expLow; logic expBrk;} row_t;
	logic clk, rst_n, porOk, undervoltBelow, overvoltAbove, currentLimitActive, powerLimitActive, breakerTrip;
	logic timerAboveHigh, timerAboveMid, timerBelowLow, limitRangePin, restartSelectPin, regWrEn;
	logic clearFaults, onOffRestart, alertLineNIn, alertLineNOut, alertLineNOe, prev;
	logic gatePullStrong, gatePullMedium, gateSource, timerInsertSource, timerFaultSource;
	logic timerSinkStrong, timerSinkWeak, limitLowRange, breakerHighMultiple;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData, rdv;
	int failCount = 0, cmpCount = 0, cycles = 0, ups;
	row_t rows [6] = '{'{8'h00, 1'h0, 1'h0, 1'h1}, '{8'h00, 1'h1, 1'h1, 1'h0}, '{8'h10, 1'h1, 1'h0, 1'h0},
		'{8'h1F, 1'h0, 1'h1, 1'h1}, '{8'h40, 1'h0, 1'h0, 1'h0}, '{8'h67, 1'h1, 1'h1, 1'h1}};

	hot_swap_fault_sequencer dut (.clk(clk), .rst_n(rst_n), .porOk(porOk), .undervoltBelow(undervoltBelow),
		.overvoltAbove(overvoltAbove), .currentLimitActive(currentLimitActive),
		.powerLimitActive(powerLimitActive), .breakerTrip(breakerTrip), .timerAboveHigh(timerAboveHigh),
		.timerAboveMid(timerAboveMid), .timerBelowLow(timerBelowLow), .limitRangePin(limitRangePin),
		.restartSelectPin(restartSelectPin), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdData(regRdData), .clearFaults(clearFaults), .onOffRestart(onOffRestart),
		.gatePullStrong(gatePullStrong), .gatePullMedium(gatePullMedium), .gateSource(gateSource),
		.timerInsertSource(timerInsertSource), .timerFaultSource(timerFaultSource),
		.timerSinkStrong(timerSinkStrong), .timerSinkWeak(timerSinkWeak), .limitLowRange(limitLowRange),
		.breakerHighMultiple(breakerHighMultiple), .alertLineNIn(alertLineNIn), .alertLineNOut(alertLineNOut),
		.alertLineNOe(alertLineNOe));
	timer_cap_model cap (.clk(clk), .insertSrc(timerInsertSource), .faultSrc(timerFaultSource),
		.sinkStrong(timerSinkStrong), .sinkWeak(timerSinkWeak), .aboveHigh(timerAboveHigh),
		.aboveMid(timerAboveMid), .belowLow(timerBelowLow));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic completeRun;
		if (failCount == 0 && cmpCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// A hang anywhere is cut off here well past the few thousand cycles the run needs.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failCount++;
			completeRun;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmpCount++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: %s", $time, msg);
			failCount++;
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string msg);
		chk({15'h0000, got}, {15'h0000, exp}, msg);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) #1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clk) #1;
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk) #1;
		regAddr = a;
		@(posedge clk) #1;
		rdv = regRdData;
	endtask
	// Inputs pass three synchroniser stages, the filter register and the state, one edge each.
	task automatic settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic restart);
		@(posedge clk) #1;
		onOffRestart = restart;
		clearFaults = ~restart;
		@(posedge clk) #1;
		onOffRestart = 1'b0;
		clearFaults = 1'b0;
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return gateSource;
			1: return gatePullMedium;
			2: return timerSinkStrong;
			3: return timerSinkWeak;
			default: return timerInsertSource;
		endcase
	endfunction
	task automatic waitFor(input int w);
		for (int n = 0; n < 3000 && pick(w) !== 1'b1; n++) @(posedge clk) #1;
		chk1(pick(w), 1'b1, "awaited output never came");
	endtask

	initial begin
		{porOk, undervoltBelow, overvoltAbove, currentLimitActive, powerLimitActive, breakerTrip} = '0;
		{limitRangePin, restartSelectPin, regWrEn, clearFaults, onOffRestart, rst_n} = '0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		alertLineNIn = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		chk1(gatePullStrong, 1'b1, "strong pull-down in reset");
		chk1(timerSinkStrong, 1'b1, "timer held low in reset");
		chk1(alertLineNOe, 1'b0, "alert idle in reset");
		chk(regRdData, 16'h0000, "read data in reset");
		rst_n = 1'b1;
		foreach (rows[i]) begin
			limitRangePin = rows[i].pin;
			wr(8'hD9, {8'h00, rows[i].cfg});
			rd(8'hD9);
			settle;
			chk(rdv, {8'h00, rows[i].cfg}, "config readback");
			chk1(limitLowRange, rows[i].expLow, "limit range");
			chk1(breakerHighMultiple, rows[i].expBrk, "breaker multiple");
		end
		limitRangePin = 1'b0;
		wr(8'hD9, 16'h0000);
		wr(8'hD8, 16'hFFFF);
		rd(8'hD8);
		chk(rdv, 16'hFFFF, "mask readback");
		wr(8'hD8, 16'h0000);
		wr(8'h80, 16'hFFFF);
		rd(8'h80);
		chk(rdv, 16'h0000, "read-only status written");
		rd(8'h55);
		chk(rdv, 16'h0000, "unmapped read");
		undervoltBelow = 1'b1;
		porOk = 1'b1;
		settle;
		chk1(gatePullMedium, 1'b1, "insertion gate hold");
		chk1(timerInsertSource, 1'b1, "insertion timer charge");
		undervoltBelow = 1'b0;
		waitFor(2);
		waitFor(0);
		undervoltBelow = 1'b1;
		settle;
		chk1(gatePullMedium, 1'b1, "undervoltage gate off");
		undervoltBelow = 1'b0;
		overvoltAbove = 1'b1;
		settle;
		chk1(gatePullMedium, 1'b1, "overvoltage gate off");
		overvoltAbove = 1'b0;
		settle;
		chk1(gateSource, 1'b1, "gate back on");
		currentLimitActive = 1'b1;
		settle;
		chk1(timerFaultSource, 1'b1, "limit charges timer");
		repeat (20) @(posedge clk);
		#1;
		currentLimitActive = 1'b0;
		settle;
		chk1(timerSinkStrong, 1'b1, "early end discharge");
		chk1(gateSource, 1'b1, "normal after limit");
		breakerTrip = 1'b1;
		settle;
		chk1(gatePullStrong, 1'b1, "breaker pull-down");
		chk1(timerFaultSource, 1'b1, "breaker timeout");
		breakerTrip = 1'b0;
		settle;
		chk1(gatePullStrong, 1'b0, "breaker release");
		chk1(alertLineNOe, 1'b1, "breaker alert");
		rd(8'h80);
		chk(rdv, 16'h0001, "vendor breaker bit");
		rd(8'hE1);
		chk(rdv & 16'h0400, 16'h0400, "diagnostic breaker bit");
		wr(8'hD8, 16'h0400);
		chk1(alertLineNOe, 1'b0, "masked alert");
		wr(8'hD8, 16'h0000);
		chk1(alertLineNOe, 1'b1, "unmasked alert");
		pulse(1'b0);
		chk1(alertLineNOe, 1'b0, "cleared alert");
		currentLimitActive = 1'b1;
		waitFor(1);
		currentLimitActive = 1'b0;
		rd(8'h7C);
		chk(rdv & 16'h0004, 16'h0004, "input overcurrent bit");
		rd(8'h79);
		chk(rdv & 16'h2000, 16'h2000, "summary input bit");
		rd(8'hE1);
		chk(rdv & 16'h0800, 16'h0800, "diagnostic overcurrent bit");
		chk1(alertLineNOe, 1'b1, "limit alert");
		ups = 0;
		for (int n = 0; n < 4000 && gateSource !== 1'b1; n++) begin
			prev = timerFaultSource;
			@(posedge clk) #1;
			if (prev === 1'b0 && timerFaultSource === 1'b1) ups++;
		end
		chk(16'(ups), 16'h0007, "restart ramp count");
		chk1(gateSource, 1'b1, "restart turns gate on");
		pulse(1'b0);
		restartSelectPin = 1'b1;
		powerLimitActive = 1'b1;
		waitFor(3);
		powerLimitActive = 1'b0;
		chk1(gatePullMedium, 1'b1, "latched gate low");
		rd(8'hE1);
		chk(rdv & 16'h0900, 16'h0900, "latched and overpower bits");
		pulse(1'b1);
		settle;
		chk1(timerSinkWeak, 1'b1, "restart waits for timer low");
		waitFor(4);
		rd(8'hE1);
		chk(rdv & 16'h0100, 16'h0000, "latched flag dropped");
		chk1(alertLineNOut, 1'b0, "alert drives low only");
		// One configured retry overrides the latch-off pin: the first timeout retries, the second latches.
		wr(8'hD9, 16'h0002);
		waitFor(0);
		currentLimitActive = 1'b1;
		waitFor(1);
		rd(8'hE1);
		chk(rdv & 16'h0100, 16'h0000, "first timeout retries");
		waitFor(0);
		waitFor(1);
		rd(8'hE1);
		chk(rdv & 16'h0100, 16'h0100, "spent budget latches");
		currentLimitActive = 1'b0;
		// A second reset in mid-run drops the faults and the configuration.
		rst_n = 1'b0;
		@(posedge clk) #1;
		chk1(gatePullStrong, 1'b1, "strong pull-down after reset");
		chk1(alertLineNOe, 1'b0, "alert released by reset");
		rst_n = 1'b1;
		rd(8'hD9);
		chk(rdv, 16'h0000, "config reset");
		completeRun;
	end
endmodule
`default_nettype wire
